// [core/port_block.sv]
// Three-port I/O block with latches, direction, pull-ups and oscillator pins.
// Assumes a single-cycle CPU register strobe on mclk and asynchronous pins.
//
// Function
// - Three pull-up registers at FF32H-FF34H, reset zero, unused bits read zero.
// - Pull-up disconnected while its select bit is zero.
// - Pull-up connected when its select bit is one.
// - Direction zero drives the pin; direction one is input, driver off.
// - Reset sets every direction bit to one.
// - Bit operations are full byte read-modify-write of the port.
// - Output mode: write loads latch, drives pin, holds until next write.
// - Input mode: write loads latch, pin unchanged.
// - Reset clears every output latch.
// - Output mode read returns latch, latch unchanged.
// - Input mode read returns pin level, latch unchanged.
// - Output mode operation uses latch, result written back and driven.
// - Input mode operation uses pin level, result to latch.
// - Internal oscillator source frees both oscillator pins as port pins.
// - External clock source frees the oscillator output pin.
`timescale 1ns/100ps
module port_block (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     srst,
   // CPU register access
   input  port_pkg::cpu_req_t            req,
   output logic [7:0]                    rdata,
   // Clock source strap
   input  port_pkg::clk_src_t            clk_src,
   // Port pins
   input  wire logic [7:0]               pin_in_two,
   input  wire logic [7:0]               pin_in_three,
   input  wire logic [7:0]               pin_in_four,
   output logic [7:0]                    pin_out_two,
   output logic [7:0]                    pin_oe_two,
   output logic [7:0]                    pin_pu_two,
   output logic [7:0]                    pin_out_three,
   output logic [7:0]                    pin_oe_three,
   output logic [7:0]                    pin_pu_three,
   output logic [7:0]                    pin_out_four,
   output logic [7:0]                    pin_oe_four,
   output logic [7:0]                    pin_pu_four,
   // Oscillator pins reused as port pins
   input  wire logic [1:0]               osc_pin_in,
   output logic [1:0]                    osc_pin_out,
   output logic [1:0]                    osc_pin_oe,
   output logic [1:0]                    osc_port_en
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input port_pkg::cpu_req_t r, input logic [15:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   logic [7:0] s1_two, s2_two, s1_three, s2_three, s1_four, s2_four;
   logic [1:0] s1_osc, s2_osc;
   always_ff @(posedge mclk) begin
      s1_two   <= pin_in_two;
      s2_two   <= s1_two;
      s1_three <= pin_in_three;
      s2_three <= s1_three;
      s1_four  <= pin_in_four;
      s2_four  <= s1_four;
      s1_osc   <= osc_pin_in;
      s2_osc   <= s1_osc;
   end

   ////////////////////////////////////////////////////////////////////////////
   port_pkg::pin_drive_t drv_two, drv_three, drv_four;
   logic [7:0] rp_two, rd_two, ru_two, rp_three, rd_three, ru_three, rp_four, rd_four, ru_four;

   port_lane #(.MASK(port_pkg::MASK_TWO)) u_two (
      .mclk(mclk), .srst(srst),
      .wr_latch(hit(req, port_pkg::ADDR_PORT_TWO)),
      .wr_dir(hit(req, port_pkg::ADDR_DIR_TWO)),
      .wr_pu(hit(req, port_pkg::ADDR_PU_TWO)),
      .wdata(req.wdata), .pin_sync(s2_two), .drive(drv_two),
      .rd_port(rp_two), .rd_dir(rd_two), .rd_pu(ru_two));
   port_lane #(.MASK(port_pkg::MASK_THREE)) u_three (
      .mclk(mclk), .srst(srst),
      .wr_latch(hit(req, port_pkg::ADDR_PORT_THREE)),
      .wr_dir(hit(req, port_pkg::ADDR_DIR_THREE)),
      .wr_pu(hit(req, port_pkg::ADDR_PU_THREE)),
      .wdata(req.wdata), .pin_sync(s2_three), .drive(drv_three),
      .rd_port(rp_three), .rd_dir(rd_three), .rd_pu(ru_three));
   port_lane #(.MASK(port_pkg::MASK_FOUR)) u_four (
      .mclk(mclk), .srst(srst),
      .wr_latch(hit(req, port_pkg::ADDR_PORT_FOUR)),
      .wr_dir(hit(req, port_pkg::ADDR_DIR_FOUR)),
      .wr_pu(hit(req, port_pkg::ADDR_PU_FOUR)),
      .wdata(req.wdata), .pin_sync(s2_four), .drive(drv_four),
      .rd_port(rp_four), .rd_dir(rd_four), .rd_pu(ru_four));

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator pins: latch and direction of their own, loaded by port two writes; pins driven and read only while freed
   logic [1:0] osc_latch_q, osc_dir_q;
   wire  [1:0] osc_free = (clk_src == port_pkg::CLK_SRC_INTERNAL) ? 2'b11 :
                          (clk_src == port_pkg::CLK_SRC_EXTERNAL) ? 2'b10 :
                          2'b00;
   always_ff @(posedge mclk) begin
      if (srst) begin
         osc_latch_q <= port_pkg::LATCH_RESET[7:6];
         osc_dir_q   <= port_pkg::DIR_RESET[7:6];
      end else begin
         if (hit(req, port_pkg::ADDR_PORT_TWO)) begin
            osc_latch_q <= req.wdata[7:6];
         end
         if (hit(req, port_pkg::ADDR_DIR_TWO)) begin
            osc_dir_q <= req.wdata[7:6];
         end
      end
   end
   wire [1:0] osc_rd = osc_free & ((osc_dir_q & s2_osc) | (~osc_dir_q & osc_latch_q));

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; port two carries oscillator pins in bits 7:6 when freed
   wire [7:0] rd_mux =
      (req.addr == port_pkg::ADDR_PORT_TWO)   ? (rp_two | {osc_rd, 6'h00}) :
      (req.addr == port_pkg::ADDR_PORT_THREE) ? rp_three :
      (req.addr == port_pkg::ADDR_PORT_FOUR)  ? rp_four :
      (req.addr == port_pkg::ADDR_DIR_TWO)    ? rd_two :
      (req.addr == port_pkg::ADDR_DIR_THREE)  ? rd_three :
      (req.addr == port_pkg::ADDR_DIR_FOUR)   ? rd_four :
      (req.addr == port_pkg::ADDR_PU_TWO)     ? ru_two :
      (req.addr == port_pkg::ADDR_PU_THREE)   ? ru_three :
      (req.addr == port_pkg::ADDR_PU_FOUR)    ? ru_four :
      port_pkg::ZERO8;

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata         <= port_pkg::ZERO8;
         pin_out_two   <= port_pkg::ZERO8;
         pin_oe_two    <= port_pkg::ZERO8;
         pin_pu_two    <= port_pkg::ZERO8;
         pin_out_three <= port_pkg::ZERO8;
         pin_oe_three  <= port_pkg::ZERO8;
         pin_pu_three  <= port_pkg::ZERO8;
         pin_out_four  <= port_pkg::ZERO8;
         pin_oe_four   <= port_pkg::ZERO8;
         pin_pu_four   <= port_pkg::ZERO8;
         osc_pin_out   <= 2'b00;
         osc_pin_oe    <= 2'b00;
         osc_port_en   <= 2'b00;
      end else begin
         if (req.rd) begin
            rdata <= rd_mux;
         end
         pin_out_two   <= drv_two.out;
         pin_oe_two    <= drv_two.oe;
         pin_pu_two    <= drv_two.pull_up;
         pin_out_three <= drv_three.out;
         pin_oe_three  <= drv_three.oe;
         pin_pu_three  <= drv_three.pull_up;
         pin_out_four  <= drv_four.out;
         pin_oe_four   <= drv_four.oe;
         pin_pu_four   <= drv_four.pull_up;
         osc_pin_out   <= osc_latch_q & osc_free;
         osc_pin_oe    <= ~osc_dir_q & osc_free;
         osc_port_en   <= osc_free;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_pu_clear;
      @(posedge mclk) disable iff (srst)
      (hit(req, port_pkg::ADDR_PU_FOUR) && req.wdata == 8'h00) |=> ##1 (pin_pu_four == 8'h00);
   endproperty
   a_pu_clear: assert property (p_pu_clear) else $error("pull-up not released");

   property p_pu_set;
      @(posedge mclk) disable iff (srst)
      (hit(req, port_pkg::ADDR_PU_FOUR) && req.wdata == 8'hFF) |=> ##1 (pin_pu_four == 8'hFF);
   endproperty
   a_pu_set: assert property (p_pu_set) else $error("pull-up not connected");

   property p_pu_three_mask;
      @(posedge mclk) disable iff (srst) req.rd && req.addr == port_pkg::ADDR_PU_THREE |=> (rdata & 8'hFB) == 8'h00;
   endproperty
   a_pu_three_mask: assert property (p_pu_three_mask) else $error("unused pull-up bit nonzero");

   property p_oe_dir;
      @(posedge mclk) disable iff (srst)
      (hit(req, port_pkg::ADDR_DIR_FOUR) && req.wdata == 8'h00) |=> ##1 (pin_oe_four == 8'hFF);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("driver not enabled");

   sequence s_write_out;
      hit(req, port_pkg::ADDR_PORT_FOUR) && rd_four == 8'h00;
   endsequence
   property p_write_drive;
      logic [7:0] v;
      @(posedge mclk) disable iff (srst)
      (s_write_out, v = req.wdata) ##1 !hit(req, port_pkg::ADDR_PORT_FOUR) && !hit(req, port_pkg::ADDR_DIR_FOUR)
      |=> pin_out_four == v && pin_oe_four == 8'hFF;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("latch not driven");

   property p_input_no_drive;
      @(posedge mclk) disable iff (srst)
      (rd_four == 8'hFF && !hit(req, port_pkg::ADDR_DIR_FOUR)) |=> ##1 pin_oe_four == 8'h00;
   endproperty
   a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");

   property p_read_latch;
      @(posedge mclk) disable iff (srst)
      (req.rd && req.addr == port_pkg::ADDR_PORT_FOUR && rd_four == 8'h00) |=> rdata == $past(drv_four.out);
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("output read not latch");

   property p_read_pin;
      @(posedge mclk) disable iff (srst)
      (req.rd && req.addr == port_pkg::ADDR_PORT_FOUR && rd_four == 8'hFF) |=> rdata == $past(s2_four);
   endproperty
   a_read_pin: assert property (p_read_pin) else $error("input read not pin");

   property p_osc_free;
      @(posedge mclk) disable iff (srst) clk_src == port_pkg::CLK_SRC_EXTERNAL |=> osc_port_en[0] == 1'b0;
   endproperty
   a_osc_free: assert property (p_osc_free) else $error("oscillator input freed wrongly");

   property p_reset_latch;
      @(posedge mclk) srst |=> ##1 pin_out_four == 8'h00 && pin_oe_four == 8'h00;
   endproperty
   a_reset_latch: assert property (p_reset_latch) else $error("reset latch not clear");

   ////////////////////////////////////////////////////////////////////////////
   // Pull-up and unimplemented-bit checks
   property p_pu_two_mask;
      @(posedge mclk) disable iff (srst)
      (req.rd && req.addr == port_pkg::ADDR_PU_TWO) |=> (rdata & ~port_pkg::MASK_TWO) == 8'h00;
   endproperty
   a_pu_two_mask: assert property (p_pu_two_mask) else $error("unused pull-up bit of port two set");

   property p_pu_two_follow;
      @(posedge mclk) disable iff (srst)
      hit(req, port_pkg::ADDR_PU_TWO) |=> ##1 pin_pu_two == ($past(req.wdata, 2) & port_pkg::MASK_TWO);
   endproperty
   a_pu_two_follow: assert property (p_pu_two_follow) else $error("pull-up does not follow register");

   property p_unused_three_quiet;
      @(posedge mclk) disable iff (srst)
      1'b1 |-> ((pin_oe_three | pin_pu_three) & ~port_pkg::MASK_THREE) == 8'h00;
   endproperty
   a_unused_three_quiet: assert property (p_unused_three_quiet) else $error("unused pin driven or pulled");

   property p_dir_three_read;
      @(posedge mclk) disable iff (srst)
      (req.rd && req.addr == port_pkg::ADDR_DIR_THREE) |=> (rdata | port_pkg::MASK_THREE) == 8'hFF;
   endproperty
   a_dir_three_read: assert property (p_dir_three_read) else $error("unused direction bit not one");

   // Latch and read-path checks
   property p_write_input;
      @(posedge mclk) disable iff (srst)
      (hit(req, port_pkg::ADDR_PORT_FOUR) && rd_four == 8'hFF)
      |=> ##1 pin_oe_four == 8'h00 && pin_out_four == $past(req.wdata, 2);
   endproperty
   a_write_input: assert property (p_write_input) else $error("input-mode write not latched");

   property p_latch_hold;
      @(posedge mclk) disable iff (srst)
      !hit(req, port_pkg::ADDR_PORT_FOUR) |=> ##1 $stable(pin_out_four);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

   property p_read_keeps_latch;
      @(posedge mclk) disable iff (srst)
      (req.rd && !req.wr) |=> $stable(drv_four.out);
   endproperty
   a_read_keeps_latch: assert property (p_read_keeps_latch) else $error("read altered latch");

   property p_rdata_hold;
      @(posedge mclk) disable iff (srst)
      !req.rd |=> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

   // Oscillator pin checks
   property p_osc_internal;
      @(posedge mclk) disable iff (srst)
      clk_src == port_pkg::CLK_SRC_INTERNAL |=> osc_port_en == 2'b11;
   endproperty
   a_osc_internal: assert property (p_osc_internal) else $error("oscillator pins not freed");

   property p_osc_external;
      @(posedge mclk) disable iff (srst)
      clk_src == port_pkg::CLK_SRC_EXTERNAL |=> osc_port_en[1] == 1'b1;
   endproperty
   a_osc_external: assert property (p_osc_external) else $error("oscillator output pin not freed");

   property p_osc_crystal;
      @(posedge mclk) disable iff (srst)
      clk_src == port_pkg::CLK_SRC_CRYSTAL |=> osc_port_en == 2'b00 && osc_pin_oe == 2'b00;
   endproperty
   a_osc_crystal: assert property (p_osc_crystal) else $error("oscillator pin driven by port");

   sequence s_osc_write;
      hit(req, port_pkg::ADDR_PORT_TWO) && clk_src == port_pkg::CLK_SRC_INTERNAL;
   endsequence
   property p_osc_latch_load;
      logic [1:0] v;
      @(posedge mclk) disable iff (srst)
      (s_osc_write, v = req.wdata[7:6]) ##1 clk_src == port_pkg::CLK_SRC_INTERNAL |=> osc_pin_out == v;
   endproperty
   a_osc_latch_load: assert property (p_osc_latch_load) else $error("freed pin not driven from latch");

   property p_osc_reset;
      @(posedge mclk) srst |=> osc_pin_out == 2'b00 && osc_pin_oe == 2'b00;
   endproperty
   a_osc_reset: assert property (p_osc_reset) else $error("oscillator pin drive not cleared");
endmodule // port_block

// [core/port_pkg.sv]
// Port block constants: register addresses, reset values, bit masks, carriers.
// Assumes an 8-bit CPU data bus with a 16-bit address on mclk.
package port_pkg;
   localparam logic [15:0] ADDR_PORT_TWO  = 16'hFF02;
   localparam logic [15:0] ADDR_PORT_THREE = 16'hFF03;
   localparam logic [15:0] ADDR_PORT_FOUR = 16'hFF04;
   localparam logic [15:0] ADDR_DIR_TWO   = 16'hFF22;
   localparam logic [15:0] ADDR_DIR_THREE = 16'hFF23;
   localparam logic [15:0] ADDR_DIR_FOUR  = 16'hFF24;
   localparam logic [15:0] ADDR_PU_TWO    = 16'hFF32;
   localparam logic [15:0] ADDR_PU_THREE  = 16'hFF33;
   localparam logic [15:0] ADDR_PU_FOUR   = 16'hFF34;
   localparam logic [7:0]  LATCH_RESET    = 8'h00;
   localparam logic [7:0]  DIR_RESET      = 8'hFF;
   localparam logic [7:0]  PU_RESET       = 8'h00;
   // Implemented bits per port; unimplemented pull-up bits and port bits read zero, except freed oscillator pins in port two bits 7:6; direction bits read one
   localparam logic [7:0]  MASK_TWO       = 8'h0F;
   localparam logic [7:0]  MASK_THREE     = 8'h04;
   localparam logic [7:0]  MASK_FOUR      = 8'hFF;
   localparam logic [7:0]  ZERO8          = 8'h00;
   // Oscillator pin bit positions in the oscillator pin group
   localparam int          OSC_IN_BIT     = 0;
   localparam int          OSC_OUT_BIT    = 1;

   typedef enum logic [1:0] {
      CLK_SRC_INTERNAL = 2'b00,
      CLK_SRC_CRYSTAL  = 2'b01,
      CLK_SRC_EXTERNAL = 2'b10
   } clk_src_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cpu_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
   } pin_drive_t;
endpackage

// [core/port_lane.sv]
// One 8-bit port: output latch, direction, pull-up and per-bit read select.
// Assumes pin_sync is already synchronised to mclk by the parent.
`timescale 1ns/100ps
module port_lane #(
   parameter logic [7:0] MASK = 8'hFF
) (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     srst,
   // Register writes
   input  wire logic                     wr_latch,
   input  wire logic                     wr_dir,
   input  wire logic                     wr_pu,
   input  wire logic [7:0]               wdata,
   // Pin side
   input  wire logic [7:0]               pin_sync,
   output port_pkg::pin_drive_t          drive,
   // Readback
   output logic [7:0]                    rd_port,
   output logic [7:0]                    rd_dir,
   output logic [7:0]                    rd_pu
);
   logic [7:0] latch_q;
   logic [7:0] dir_q;
   logic [7:0] pu_q;
   wire  [7:0] latch_d = wdata & MASK;
   wire  [7:0] dir_d   = wdata | ~MASK;
   wire  [7:0] pu_d    = wdata & MASK;

   // Latch loads in either mode; reset clears it
   always_ff @(posedge mclk) begin
      if (srst) begin
         latch_q <= port_pkg::LATCH_RESET;
      end else if (wr_latch) begin
         latch_q <= latch_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         dir_q <= port_pkg::DIR_RESET;
         pu_q  <= port_pkg::PU_RESET;
      end else begin
         if (wr_dir) begin
            dir_q <= dir_d;
         end
         if (wr_pu) begin
            pu_q <= pu_d;
         end
      end
   end

   // Per-bit source: pin in input mode, latch in output mode
   assign rd_port = ((dir_q & pin_sync) | (~dir_q & latch_q)) & MASK;
   assign rd_dir  = dir_q;
   assign rd_pu   = pu_q & MASK;

   // Zero direction enables the driver; pull-up only when bit set
   assign drive.out     = latch_q;
   assign drive.oe      = ~dir_q & MASK;
   assign drive.pull_up = pu_q & MASK;

   property p_reset_dir;
      @(posedge mclk) srst |=> (dir_q == port_pkg::DIR_RESET && latch_q == port_pkg::LATCH_RESET);
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("reset values wrong");
endmodule // port_lane

// [bench/pin_partner.sv]
// External parties on one 8-bit port: bench driver, pull-up or floating.
// The device driver wins where the bench also enables its driver on the same pin.
`timescale 1ns/100ps
module pin_partner (
   // Clock
   input  wire logic       mclk,
   // Device side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pu,
   // External driver
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   // Resolved wire level
   output logic [7:0]      pin_lvl
);
   logic [7:0] float_q = 8'h55;
   // Undriven lines wander
   always_ff @(posedge mclk) float_q <= ~float_q;
   always_comb
      for (int i = 0; i < 8; i++)
         pin_lvl[i] = pin_oe[i] ? pin_out[i] :
                      ext_en[i] ? ext_val[i] : pin_pu[i] ? 1'b1 : float_q[i];
endmodule // pin_partner

// [bench/tb_top.sv]
// Self-checking bench for the three-port block.
// Assumes pin_partner models the parties on each port.
`timescale 1ns/100ps
module tb_top;
   logic                mclk = 1'b0;
   logic                srst = 1'b1;
   port_pkg::cpu_req_t  req = '0;
   port_pkg::clk_src_t  clk_src = port_pkg::CLK_SRC_CRYSTAL;
   logic [7:0]          rdata;
   logic [7:0]          lvl [3];
   logic [7:0]          pout [3];
   logic [7:0]          poe [3];
   logic [7:0]          ppu [3];
   logic [7:0]          ext_val [3] = '{8'h00, 8'h00, 8'h3C};
   logic [7:0]          ext_en [3] = '{8'hFF, 8'hFF, 8'hFF};
   logic [1:0]          osc_en;
   logic [1:0]          osc_out;
   logic [1:0]          osc_oe;
   logic [1:0]          osc_in = 2'b00;
   int                  error_cnt = 0;
   int                  samples_checked = 0;
   logic [7:0]          d;

   initial forever #12.5 mclk = ~mclk;

   port_block dut_u (.mclk(mclk), .srst(srst), .req(req), .rdata(rdata), .clk_src(clk_src),
      .pin_in_two(lvl[0]), .pin_in_three(lvl[1]), .pin_in_four(lvl[2]),
      .pin_out_two(pout[0]), .pin_oe_two(poe[0]), .pin_pu_two(ppu[0]),
      .pin_out_three(pout[1]), .pin_oe_three(poe[1]), .pin_pu_three(ppu[1]),
      .pin_out_four(pout[2]), .pin_oe_four(poe[2]), .pin_pu_four(ppu[2]),
      .osc_pin_in(osc_in), .osc_pin_out(osc_out), .osc_pin_oe(osc_oe), .osc_port_en(osc_en));

   for (genvar g = 0; g < 3; g++) begin : g_pp
      pin_partner pp_u (.mclk(mclk), .pin_out(pout[g]), .pin_oe(poe[g]), .pin_pu(ppu[g]),
         .ext_val(ext_val[g]), .ext_en(ext_en[g]), .pin_lvl(lvl[g]));
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge mclk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = v;
      @(negedge mclk);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge mclk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge mclk);
      v = rdata;
      req.rd = 1'b0;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk_rd(port_pkg::ADDR_PU_TWO, 8'h00);
      chk_rd(port_pkg::ADDR_PU_THREE, 8'h00);
      chk_rd(port_pkg::ADDR_PU_FOUR, 8'h00);
      chk_rd(port_pkg::ADDR_DIR_FOUR, 8'hFF);
      chk_rd(port_pkg::ADDR_DIR_THREE, 8'hFF);
      chk(pout[2], 8'h00);
      chk(poe[2], 8'h00);
      chk(ppu[2], 8'h00);
   endtask

   task automatic t_pullup;
      wr(port_pkg::ADDR_PU_TWO, 8'hFF);
      wr(port_pkg::ADDR_PU_THREE, 8'hFF);
      wr(port_pkg::ADDR_PU_FOUR, 8'hFF);
      wr(16'hFF35, 8'hFF);
      chk_rd(port_pkg::ADDR_PU_TWO, port_pkg::MASK_TWO);
      chk_rd(port_pkg::ADDR_PU_THREE, port_pkg::MASK_THREE);
      chk_rd(port_pkg::ADDR_PU_FOUR, 8'hFF);
      chk_rd(16'hFF35, 8'h00);
      chk(ppu[2], 8'hFF);
      chk(ppu[0], port_pkg::MASK_TWO);
      chk(ppu[1], port_pkg::MASK_THREE);
      wr(port_pkg::ADDR_PU_FOUR, 8'h5A);
      repeat (3) @(negedge mclk);
      chk(ppu[2], 8'h5A);
      wr(port_pkg::ADDR_PU_FOUR, 8'h00);
      repeat (3) @(negedge mclk);
      chk(ppu[2], 8'h00);
   endtask

   task automatic t_input_write;
      wr(port_pkg::ADDR_PORT_FOUR, 8'hA5);
      repeat (4) @(negedge mclk);
      chk(poe[2], 8'h00);
      chk_rd(port_pkg::ADDR_PORT_FOUR, 8'h3C);
      chk_rd(port_pkg::ADDR_PORT_FOUR, 8'h3C);
   endtask

   task automatic t_output;
      ext_en[2] = 8'h00;
      wr(port_pkg::ADDR_DIR_FOUR, 8'h00);
      repeat (4) @(negedge mclk);
      chk(poe[2], 8'hFF);
      chk(pout[2], 8'hA5);
      chk_rd(port_pkg::ADDR_PORT_FOUR, 8'hA5);
      chk_rd(port_pkg::ADDR_PORT_FOUR, 8'hA5);
      chk(pout[2], 8'hA5);
   endtask

   task automatic t_mixed_rmw;
      wr(port_pkg::ADDR_DIR_FOUR, 8'hF0);
      ext_en[2] = 8'hF0;
      repeat (5) @(negedge mclk);
      rd(port_pkg::ADDR_PORT_FOUR, d);
      chk(d, 8'h35);
      wr(port_pkg::ADDR_PORT_FOUR, d | 8'h08);
      wr(port_pkg::ADDR_DIR_FOUR, 8'h00);
      ext_en[2] = 8'h00;
      repeat (4) @(negedge mclk);
      chk(pout[2], 8'h3D);
      chk_rd(port_pkg::ADDR_PORT_FOUR, 8'h3D);
      wr(port_pkg::ADDR_PORT_FOUR, 8'hC3);
      repeat (3) @(negedge mclk);
      chk(pout[2], 8'hC3);
   endtask

   task automatic t_osc;
      clk_src = port_pkg::CLK_SRC_INTERNAL;
      osc_in = 2'b01;
      wr(port_pkg::ADDR_DIR_TWO, 8'h40);
      wr(port_pkg::ADDR_PORT_TWO, 8'h80);
      repeat (3) @(negedge mclk);
      chk(poe[0], 8'h0F);
      chk({osc_out, osc_oe, 2'b00, osc_en}, 8'hA3);
      chk_rd(port_pkg::ADDR_PORT_TWO, 8'hC0);
      clk_src = port_pkg::CLK_SRC_EXTERNAL;
      repeat (3) @(negedge mclk);
      chk({osc_out, osc_oe, 2'b00, osc_en}, 8'hA2);
      chk_rd(port_pkg::ADDR_PORT_TWO, 8'h80);
      clk_src = port_pkg::CLK_SRC_CRYSTAL;
      repeat (3) @(negedge mclk);
      chk({osc_out, osc_oe, 2'b00, osc_en}, 8'h00);
      chk_rd(port_pkg::ADDR_PORT_TWO, 8'h00);
   endtask

   task automatic t_rerun;
      srst = 1'b1;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      t_reset();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (6) @(negedge mclk);
      srst = 1'b0;
      t_reset();
      t_pullup();
      t_input_write();
      t_output();
      t_mixed_rmw();
      t_osc();
      t_rerun();
      finish_test();
   end
endmodule // tb_top
